/* File: shared/daco_pkg.sv */
// shared constants and types for the dual converter conversion and averaging control
//
// What this block does
// R1 - software mode configures from registers, hardware from pins
// R2 - eight inputs; diagnostic channel only in software
// R3 - channel from pins in hardware, register otherwise
// R4 - hardware pairs equal indices; software pairs freely
// R5 - range code: 0 registers, 1/2/3 fixed ranges; in hardware mode a pin code of 0 keeps the last range
// R6 - per-channel range registers in software mode
// R7 - host allows 120 us after range pin change
// R8 - results are 14-bit twos complement
// R9 - code weight is span over 16384
// R10 - reference pin high enables internal reference
// R11 - reference mode latched; buffer always enabled
// R12 - reset held low over 1.2 us shuts down
// R13 - reset rising edge leaves shutdown
// R14 - host waits 240 us / 15 ms after wake
// R15 - shutdown clears every register to default
// R16 - software ratio field applies to all channels
// R17 - hardware ratio pins latched at reset release
// R18 - ratio code n gives two to the n
// R19 - average samples, reduce to 14 bits
// R20 - trigger takes first sample, rest internally strobed
// R21 - busy length grows linearly with ratio
// R22 - sequencer advances only after all channel samples
// R23 - mode latched from range pins at release
// R24 - register access refused in hardware mode
// R25 - busy from trigger until final average ready
package daco_pkg;

	// ****************
	// timing
	// ****************
	localparam int CLK_PERIOD_NS    = 50;
	localparam int SHUTDOWN_TIME_NS = 1200;
	localparam int SHUTDOWN_CYCLES  = (SHUTDOWN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SAMPLE_GAP_DEF   = 4;

	// ****************
	// data widths and code weights
	// ****************
	localparam int RESULT_BITS   = 14;
	localparam int RATIO_LOG_MAX = 7;
	localparam int ACC_BITS      = RESULT_BITS + RATIO_LOG_MAX;
	localparam int CODE_STEPS    = 16384;
	localparam int SPAN_2V5_UV   = 5000000;
	localparam int SPAN_5V_UV    = 10000000;
	localparam int SPAN_10V_UV   = 20000000;
	localparam logic [10:0] LSB_UV_2V5 = 11'(SPAN_2V5_UV / CODE_STEPS);
	localparam logic [10:0] LSB_UV_5V  = 11'(SPAN_5V_UV / CODE_STEPS);
	localparam logic [10:0] LSB_UV_10V = 11'(SPAN_10V_UV / CODE_STEPS);

	// ****************
	// range codes and channels
	// ****************
	localparam logic [1:0] RANGE_SOFT = 2'h0;
	localparam logic [1:0] RANGE_2V5  = 2'h1;
	localparam logic [1:0] RANGE_5V   = 2'h2;
	localparam logic [1:0] RANGE_10V  = 2'h3;
	localparam logic [3:0] DIAG_CHANNEL = 4'h8;

	// ****************
	// register map, fields and reset values
	// ****************
	localparam logic [7:0]  REG_CONFIG   = 8'h00;
	localparam logic [7:0]  REG_CHANNEL  = 8'h04;
	localparam logic [7:0]  REG_RANGE_A  = 8'h08;
	localparam logic [7:0]  REG_RANGE_B  = 8'h0C;
	localparam logic [7:0]  REG_STATUS   = 8'h10;
	localparam logic [6:0]  CONFIG_RESET  = 7'h00;
	localparam logic [7:0]  CHANNEL_RESET = 8'h00;
	localparam logic [15:0] RANGE_RESET   = 16'hFFFF;
	localparam int ST_BUSY_BIT  = 0;
	localparam int ST_HW_BIT    = 1;
	localparam int ST_REF_BIT   = 2;
	localparam int ST_RATIO_LSB = 4;

	typedef struct packed {
		logic [2:0] seq_last;
		logic       seq_en;
		logic [2:0] avg_ratio_field;
	} daco_cfg_s;

	typedef struct packed {
		logic [3:0] b;
		logic [3:0] a;
	} daco_chan_s;

	typedef struct packed {
		logic [RESULT_BITS-1:0] b;
		logic [RESULT_BITS-1:0] a;
	} daco_result_s;

	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_GAP} daco_state_e;

endpackage

/* File: logic/daco_ctrl.sv */
// conversion control, configuration latching and averaging filter of the dual converter
//
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module daco_ctrl #(
	parameter int SAMPLE_GAP = daco_pkg::SAMPLE_GAP_DEF
) (
	// clock and reset
	input  wire logic                 CLK_SYS,
	input  wire logic                 RST,
	// device pins from the host
	input  wire logic                 DEV_RESET_N,
	input  wire logic [1:0]           RANGE_CODE_PINS,
	input  wire logic [2:0]           CHANNEL_PICK_PINS,
	input  wire logic                 REFERENCE_CHOICE_PIN,
	input  wire logic [2:0]           AVG_RATIO_PINS,
	input  wire logic                 CONVERSION_TRIGGER,
	// converter core side
	output logic                      SAMPLE_STROBE,
	input  wire logic                 ADC_DATA_VALID,
	input  wire logic [13:0]          ADC_A_DATA,
	input  wire logic [13:0]          ADC_B_DATA,
	output logic [3:0]                CH_A_SEL,
	output logic [3:0]                CH_B_SEL,
	output logic [1:0]                RANGE_A_SEL,
	output logic [1:0]                RANGE_B_SEL,
	output logic [10:0]               LSB_UV_A,
	output logic [10:0]               LSB_UV_B,
	// results and status
	output daco_pkg::daco_result_s    RESULT,
	output logic                      RESULT_VALID,
	output logic                      BUSY,
	output logic                      HW_MODE,
	output logic                      REF_INT_EN,
	output logic                      REF_BUF_EN,
	output logic                      SHUTDOWN,
	// AHB-Lite register slave
	input  wire logic                 HSEL,
	input  wire logic [31:0]          HADDR,
	input  wire logic [1:0]           HTRANS,
	input  wire logic                 HWRITE,
	input  wire logic [2:0]           HSIZE,
	input  wire logic [31:0]          HWDATA,
	input  wire logic                 HREADY,
	output logic                      HREADYOUT,
	output logic [31:0]               HRDATA,
	output logic                      HRESP
);

	// ****************
	// declarations
	// ****************
	localparam logic [4:0] SHUT_CNT = 5'(daco_pkg::SHUTDOWN_CYCLES);
	localparam logic [3:0] GAP_LAST = 4'(SAMPLE_GAP - 1);

	logic                      reset_pin_q;
	logic                      release_edge;
	logic [4:0]                low_cnt;
	logic [2:0]                ratio_hw;
	logic [1:0]                hw_range;
	daco_pkg::daco_cfg_s       cfg;
	daco_pkg::daco_chan_s      chan;
	logic [15:0]               range_a;
	logic [15:0]               range_b;
	logic                      wr_pend;
	logic [7:0]                wr_addr;
	logic                      addr_ok;
	logic [31:0]               next_rdata;
	logic                      trig_q;
	logic                      trig_rise;
	daco_pkg::daco_state_e     state;
	logic [7:0]                sample_cnt;
	logic [3:0]                gap_cnt;
	logic [2:0]                seq_step;
	logic [2:0]                ratio_code;
	logic [7:0]                last_sample;
	logic signed [20:0]        acc_a;
	logic signed [20:0]        acc_b;
	logic signed [20:0]        sum_a;
	logic signed [20:0]        sum_b;
	logic signed [20:0]        avg_a;
	logic signed [20:0]        avg_b;
	logic [3:0]                next_ch_a;
	logic [3:0]                next_ch_b;
	logic [1:0]                next_rng_a;
	logic [1:0]                next_rng_b;

	// ****************
	// helpers
	// ****************
	// range field of one channel; the diagnostic channel runs on the widest range
	function automatic logic [1:0] pick_range(input logic [15:0] regs, input logic [3:0] ch);
		logic [1:0] code;
		code = daco_pkg::RANGE_10V;
		if (!ch[3]) begin
			code = regs[{ch[2:0], 1'b0} +: 2];
		end
		if (code == daco_pkg::RANGE_SOFT) begin
			code = daco_pkg::RANGE_10V;
		end
		return code;
	endfunction

	// weight of one code step for a range code
	function automatic logic [10:0] lsb_of(input logic [1:0] code);
		logic [10:0] w;
		w = daco_pkg::LSB_UV_10V;
		if (code == daco_pkg::RANGE_2V5) begin
			w = daco_pkg::LSB_UV_2V5;
		end else if (code == daco_pkg::RANGE_5V) begin
			w = daco_pkg::LSB_UV_5V;
		end
		return w;
	endfunction

	// software may name channels 0..7 or the diagnostic channel; larger values fold to it
	function automatic logic [3:0] legal_ch(input logic [3:0] ch);
		return ch[3] ? daco_pkg::DIAG_CHANNEL : ch;
	endfunction

	// ****************
	// reset pin, shutdown and latched straps
	// ****************
	assign release_edge = DEV_RESET_N & ~reset_pin_q;

	// previous level of the device reset pin
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			reset_pin_q <= 1'b0;
		end else begin
			reset_pin_q <= DEV_RESET_N;
		end
	end

	// low-time counter; shutdown only once the pin stayed low past the limit
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			low_cnt  <= 5'h00;
			SHUTDOWN <= 1'b0;
		end else if (DEV_RESET_N) begin
			low_cnt  <= 5'h00;
			SHUTDOWN <= 1'b0; // R13
		end else begin
			if (low_cnt != SHUT_CNT) begin
				low_cnt <= low_cnt + 5'h01;
			end
			if (low_cnt == SHUT_CNT) begin
				SHUTDOWN <= 1'b1; // R12
			end
		end
	end

	// straps are caught by the clock at the release edge, never by the async reset
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			HW_MODE    <= 1'b0;
			REF_INT_EN <= 1'b0;
			REF_BUF_EN <= 1'b1;
			ratio_hw   <= 3'h0;
		end else begin
			REF_BUF_EN <= 1'b1; // R11
			if (release_edge) begin
				HW_MODE    <= (RANGE_CODE_PINS != daco_pkg::RANGE_SOFT); // R23
				REF_INT_EN <= REFERENCE_CHOICE_PIN; // R10 R11
				ratio_hw   <= AVG_RATIO_PINS; // R17
			end
		end
	end

	// ****************
	// register file over AHB-Lite
	// ****************
	// refused in hardware mode and while the device is held in reset
	assign addr_ok = HSEL & HREADY & HTRANS[1] & ~HW_MODE & DEV_RESET_N; // R24

	// address phase capture for writes
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= addr_ok & HWRITE;
			if (addr_ok & HWRITE) begin
				wr_addr <= HADDR[7:0];
			end
		end
	end

	// writable registers; any low level on the reset pin restores defaults
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			cfg     <= daco_pkg::CONFIG_RESET;
			chan    <= daco_pkg::CHANNEL_RESET;
			range_a <= daco_pkg::RANGE_RESET;
			range_b <= daco_pkg::RANGE_RESET;
		end else if (!DEV_RESET_N) begin
			cfg     <= daco_pkg::CONFIG_RESET; // R15
			chan    <= daco_pkg::CHANNEL_RESET;
			range_a <= daco_pkg::RANGE_RESET;
			range_b <= daco_pkg::RANGE_RESET;
		end else if (wr_pend && !HW_MODE) begin
			unique case (wr_addr)
				daco_pkg::REG_CONFIG:  cfg <= HWDATA[6:0]; // R16
				daco_pkg::REG_CHANNEL: begin
					chan.a <= legal_ch(HWDATA[3:0]); // R3 R4
					chan.b <= legal_ch(HWDATA[7:4]);
				end
				daco_pkg::REG_RANGE_A: range_a <= HWDATA[15:0]; // R6
				daco_pkg::REG_RANGE_B: range_b <= HWDATA[15:0];
				default: ;
			endcase
		end
	end

	// read mux evaluated in the address phase; unmapped reads as zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (HADDR[7:0])
			daco_pkg::REG_CONFIG:  next_rdata = {25'h0, cfg};
			daco_pkg::REG_CHANNEL: next_rdata = {24'h0, chan};
			daco_pkg::REG_RANGE_A: next_rdata = {16'h0, range_a};
			daco_pkg::REG_RANGE_B: next_rdata = {16'h0, range_b};
			daco_pkg::REG_STATUS: begin
				next_rdata[daco_pkg::ST_BUSY_BIT] = BUSY;
				next_rdata[daco_pkg::ST_HW_BIT] = HW_MODE;
				next_rdata[daco_pkg::ST_REF_BIT] = REF_INT_EN;
				next_rdata[daco_pkg::ST_RATIO_LSB +: 3] = ratio_code;
			end
			default: ;
		endcase
	end

	// zero-wait slave, always OKAY; refused reads return zero
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			HRDATA    <= 32'h0000_0000;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
			if (addr_ok && !HWRITE) begin
				HRDATA <= next_rdata;
			end else if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
				HRDATA <= 32'h0000_0000; // R24
			end
		end
	end

	// ****************
	// channel and range selection
	// ****************
	// hardware ties both groups to the pin index; software may pair freely
	always_comb begin
		next_ch_a = chan.a; // R1
		next_ch_b = chan.b;
		if (HW_MODE) begin
			next_ch_a = {1'b0, CHANNEL_PICK_PINS}; // R3 R4
			next_ch_b = {1'b0, CHANNEL_PICK_PINS};
		end else if (cfg.seq_en) begin
			next_ch_a = {1'b0, seq_step}; // R22
			next_ch_b = {1'b0, seq_step};
		end
	end

	// pins act at once in hardware mode; code zero there keeps the last range
	assign hw_range = (RANGE_CODE_PINS == daco_pkg::RANGE_SOFT) ? RANGE_A_SEL : RANGE_CODE_PINS;

	always_comb begin
		next_rng_a = pick_range(range_a, next_ch_a); // R6
		next_rng_b = pick_range(range_b, next_ch_b);
		if (HW_MODE) begin
			next_rng_a = hw_range; // R5
			next_rng_b = hw_range;
		end
	end

	// selected channels, ranges and code weights toward the converter core
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			CH_A_SEL    <= 4'h0;
			CH_B_SEL    <= 4'h0;
			RANGE_A_SEL <= daco_pkg::RANGE_10V;
			RANGE_B_SEL <= daco_pkg::RANGE_10V;
			LSB_UV_A    <= daco_pkg::LSB_UV_10V;
			LSB_UV_B    <= daco_pkg::LSB_UV_10V;
		end else begin
			CH_A_SEL    <= next_ch_a; // R2
			CH_B_SEL    <= next_ch_b;
			RANGE_A_SEL <= next_rng_a;
			RANGE_B_SEL <= next_rng_b;
			LSB_UV_A    <= lsb_of(next_rng_a); // R9
			LSB_UV_B    <= lsb_of(next_rng_b);
		end
	end

	// ****************
	// oversampling conversion sequence
	// ****************
	assign ratio_code  = HW_MODE ? ratio_hw : cfg.avg_ratio_field; // R16 R17
	assign last_sample = 8'((9'h001 << ratio_code) - 9'h001); // R18
	assign trig_rise   = CONVERSION_TRIGGER & ~trig_q;

	// sign-extended running sums and the shifted mean
	assign sum_a = acc_a + 21'(signed'(ADC_A_DATA)); // R8
	assign sum_b = acc_b + 21'(signed'(ADC_B_DATA));
	assign avg_a = sum_a >>> ratio_code; // R19
	assign avg_b = sum_b >>> ratio_code;

	// trigger edge detector
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			trig_q <= 1'b0;
		end else begin
			trig_q <= CONVERSION_TRIGGER;
		end
	end

	// one sample per strobe; busy spans all samples of all sequenced pairs
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			state         <= daco_pkg::ST_IDLE;
			BUSY          <= 1'b0;
			SAMPLE_STROBE <= 1'b0;
			RESULT_VALID  <= 1'b0;
			RESULT        <= '0;
			sample_cnt    <= 8'h00;
			gap_cnt       <= 4'h0;
			seq_step      <= 3'h0;
			acc_a         <= '0;
			acc_b         <= '0;
		end else if (!DEV_RESET_N) begin
			state         <= daco_pkg::ST_IDLE; // R15
			BUSY          <= 1'b0;
			SAMPLE_STROBE <= 1'b0;
			RESULT_VALID  <= 1'b0;
			seq_step      <= 3'h0;
		end else begin
			SAMPLE_STROBE <= 1'b0;
			RESULT_VALID  <= 1'b0;
			unique case (state)
				daco_pkg::ST_IDLE: begin
					if (trig_rise) begin
						BUSY          <= 1'b1; // R25
						SAMPLE_STROBE <= 1'b1; // R20
						sample_cnt    <= 8'h00;
						seq_step      <= 3'h0;
						acc_a         <= '0;
						acc_b         <= '0;
						state         <= daco_pkg::ST_WAIT;
					end
				end
				daco_pkg::ST_WAIT: begin
					if (ADC_DATA_VALID) begin
						gap_cnt <= 4'h0;
						if (sample_cnt == last_sample) begin
							RESULT.a     <= avg_a[13:0]; // R19
							RESULT.b     <= avg_b[13:0];
							RESULT_VALID <= 1'b1;
							sample_cnt   <= 8'h00;
							acc_a        <= '0;
							acc_b        <= '0;
							if (!HW_MODE && cfg.seq_en && seq_step != cfg.seq_last) begin
								seq_step <= seq_step + 3'h1; // R22
								state    <= daco_pkg::ST_GAP;
							end else begin
								BUSY  <= 1'b0; // R25
								state <= daco_pkg::ST_IDLE;
							end
						end else begin
							sample_cnt <= sample_cnt + 8'h01; // R21
							acc_a      <= sum_a;
							acc_b      <= sum_b;
							state      <= daco_pkg::ST_GAP;
						end
					end
				end
				daco_pkg::ST_GAP: begin
					gap_cnt <= gap_cnt + 4'h1;
					if (gap_cnt == GAP_LAST) begin
						SAMPLE_STROBE <= 1'b1; // R20
						state         <= daco_pkg::ST_WAIT;
					end
				end
			endcase
		end
	end

endmodule

/* File: tb/daco_ctrl_monitor.sv */
// assertion checker for the conversion control block
`timescale 1ns/1ps
module daco_ctrl_monitor #(
	parameter int SAMPLE_GAP = 4
) (
	// clock and reset
	input wire logic        CLK_SYS,
	input wire logic        RST,
	// host pins
	input wire logic        DEV_RESET_N,
	input wire logic [1:0]  RANGE_CODE_PINS,
	input wire logic        CONVERSION_TRIGGER,
	// converter core side
	input wire logic        SAMPLE_STROBE,
	input wire logic        ADC_DATA_VALID,
	input wire logic [3:0]  CH_A_SEL,
	input wire logic [3:0]  CH_B_SEL,
	input wire logic [1:0]  RANGE_A_SEL,
	input wire logic [1:0]  RANGE_B_SEL,
	input wire logic [10:0] LSB_UV_A,
	// status
	input wire logic        RESULT_VALID,
	input wire logic        BUSY,
	input wire logic        HW_MODE,
	input wire logic        REF_BUF_EN,
	input wire logic        SHUTDOWN,
	// register bus
	input wire logic        HSEL,
	input wire logic [1:0]  HTRANS,
	input wire logic        HWRITE,
	input wire logic        HREADY,
	input wire logic        HREADYOUT,
	input wire logic [31:0] HRDATA,
	input wire logic        HRESP
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);

	// ****************
	// helper logic
	// ****************
	logic [4:0] low_cnt;
	// saturating low-sample count
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			low_cnt <= 5'h00;
		end else if (DEV_RESET_N) begin
			low_cnt <= 5'h00;
		end else if (low_cnt != 5'h1F) begin
			low_cnt <= low_cnt + 5'h01;
		end
	end

	// ****************
	// sequences and assertions
	// ****************
	sequence s_take;
		CONVERSION_TRIGGER && !$past(CONVERSION_TRIGGER) && !BUSY && DEV_RESET_N && $past(DEV_RESET_N);
	endsequence
	sequence s_first;
		BUSY && SAMPLE_STROBE;
	endsequence
	sequence s_mid;
		ADC_DATA_VALID && BUSY ##1 BUSY && !RESULT_VALID;
	endsequence

	AST_BUF_ON: assert property (REF_BUF_EN) else $error("reference buffer off");
	AST_TAKE: assert property (s_take |=> s_first) else $error("trigger not taken");
	AST_GAP: assert property (s_mid |-> ##SAMPLE_GAP SAMPLE_STROBE) else $error("strobe late");
	AST_STROBE_BUSY: assert property (SAMPLE_STROBE |-> BUSY) else $error("strobe idle");
	AST_DONE: assert property ($fell(BUSY) && $past(DEV_RESET_N) |-> RESULT_VALID)
		else $error("busy fell without result");
	AST_RESULT: assert property (RESULT_VALID |-> $past(ADC_DATA_VALID))
		else $error("result without sample");
	AST_HW_PAIR: assert property (HW_MODE |-> CH_A_SEL == CH_B_SEL && RANGE_A_SEL == RANGE_B_SEL)
		else $error("hardware pairing broken");
	AST_HW_RANGE: assert property (HW_MODE && DEV_RESET_N && RANGE_CODE_PINS != 2'h0
		|=> RANGE_A_SEL == $past(RANGE_CODE_PINS)) else $error("range pins ignored");
	AST_LSB: assert property (LSB_UV_A == (RANGE_A_SEL == 2'h1 ? 11'h131 :
		RANGE_A_SEL == 2'h2 ? 11'h262 : 11'h4C4)) else $error("code weight wrong");
	AST_SHUT_ENTER: assert property (!DEV_RESET_N |=> SHUTDOWN == ($past(low_cnt) >= 5'h18))
		else $error("shutdown entry wrong");
	AST_SHUT_EXIT: assert property (DEV_RESET_N |=> !SHUTDOWN) else $error("shutdown held");
	AST_HW_REFUSE: assert property (HW_MODE && DEV_RESET_N && HSEL && HREADY && HTRANS[1] && !HWRITE
		|=> HRDATA == 32'h0) else $error("register read in hw mode");
	AST_BUS_OKAY: assert property (HREADYOUT && !HRESP) else $error("bus response wrong");
endmodule

bind daco_ctrl daco_ctrl_monitor #(.SAMPLE_GAP(SAMPLE_GAP)) u_mon (
	.CLK_SYS(CLK_SYS), .RST(RST), .DEV_RESET_N(DEV_RESET_N), .RANGE_CODE_PINS(RANGE_CODE_PINS),
	.CONVERSION_TRIGGER(CONVERSION_TRIGGER), .SAMPLE_STROBE(SAMPLE_STROBE),
	.ADC_DATA_VALID(ADC_DATA_VALID), .CH_A_SEL(CH_A_SEL), .CH_B_SEL(CH_B_SEL),
	.RANGE_A_SEL(RANGE_A_SEL), .RANGE_B_SEL(RANGE_B_SEL), .LSB_UV_A(LSB_UV_A),
	.RESULT_VALID(RESULT_VALID), .BUSY(BUSY), .HW_MODE(HW_MODE), .REF_BUF_EN(REF_BUF_EN),
	.SHUTDOWN(SHUTDOWN), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
	.HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP)
);

/* File: tb/daco_core_model.sv */
// behavioural converter core answering sample strobes
`timescale 1ns/1ps
module daco_core_model (
	// clock and reset
	input  wire logic       CLK_SYS,
	input  wire logic       RST,
	// controls from the block and the bench
	input  wire logic       SLOW,
	input  wire logic       SAMPLE_STROBE,
	input  wire logic       BUSY,
	input  wire logic       RESULT_VALID,
	input  wire logic [3:0] CH_A_SEL,
	input  wire logic [3:0] CH_B_SEL,
	// sample pair back to the block
	output logic            ADC_DATA_VALID,
	output logic [13:0]     ADC_A_DATA,
	output logic [13:0]     ADC_B_DATA
);
	localparam logic [13:0] BASE_A = 14'h3F00;
	localparam logic [13:0] BASE_B = 14'h0100;
	logic [2:0] wait_cnt;
	logic [7:0] idx;

	// slow setting stretches the answer
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			wait_cnt <= 3'h0;
		end else if (SAMPLE_STROBE) begin
			wait_cnt <= SLOW ? 3'h5 : 3'h1;
		end else if (wait_cnt != 3'h0) begin
			wait_cnt <= wait_cnt - 3'h1;
		end
	end
	// invalid cycles toggle the data lines
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			ADC_DATA_VALID <= 1'b0;
			ADC_A_DATA     <= 14'h0000;
			ADC_B_DATA     <= 14'h0000;
		end else if (wait_cnt == 3'h1) begin
			ADC_DATA_VALID <= 1'b1;
			ADC_A_DATA     <= BASE_A + 14'({CH_A_SEL, 4'h0}) + 14'(idx);
			ADC_B_DATA     <= BASE_B + 14'({CH_B_SEL, 4'h0}) - 14'(idx);
		end else begin
			ADC_DATA_VALID <= 1'b0;
			ADC_A_DATA     <= ~ADC_A_DATA;
			ADC_B_DATA     <= ~ADC_B_DATA;
		end
	end
	// sample index restarts with each channel pair
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			idx <= 8'h00;
		end else if (ADC_DATA_VALID) begin
			idx <= idx + 8'h01;
		end else if (RESULT_VALID || !BUSY) begin
			idx <= 8'h00;
		end
	end
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the conversion control block
`timescale 1ns/1ps
module tb_top;
	localparam int GAP = 2;
	localparam int LIMIT = 20000;
	localparam logic [13:0] BA = 14'h3F00;
	localparam logic [13:0] BB = 14'h0100;
	typedef struct packed {
		logic [2:0] code; logic [3:0] cha; logic [3:0] chb; logic [15:0] rng; logic slow;
	} daco_row_s;

	// ****************
	// signals
	// ****************
	logic CLK_SYS, RST, dev_reset_n, ref_pin, trig, hsel, hwrite, slow;
	logic [1:0] rpins, htrans, rng_a, rng_b;
	logic [2:0] chpins, ospins;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic strobe, adc_valid, res_valid, busy, hw_mode, ref_int, ref_buf, shutdown, hreadyout, hresp;
	logic [13:0] adc_a, adc_b;
	logic [3:0] ch_a, ch_b, eca, ecb;
	logic [10:0] lsb_a, lsb_b;
	logic [1:0] er;
	daco_pkg::daco_result_s result;
	daco_pkg::daco_result_s res_q[$];
	daco_row_s r;
	int err_count, checked, cyc, n_strobe, busy_len, n, lat;
	// ordinary cases
	daco_row_s rows [8] = '{'{3'h0, 4'h1, 4'h6, 16'h0004, 1'b0}, '{3'h1, 4'h2, 4'h2, 16'h0020, 1'b1},
		'{3'h2, 4'h7, 4'h0, 16'h0000, 1'b0}, '{3'h3, 4'h0, 4'h7, 16'hFFFE, 1'b0},
		'{3'h4, 4'h8, 4'h9, 16'h5555, 1'b0}, '{3'h5, 4'h3, 4'h4, 16'h0040, 1'b0},
		'{3'h6, 4'h5, 4'h1, 16'hFFFF, 1'b0}, '{3'h7, 4'h6, 4'h5, 16'h1000, 1'b0}};

	daco_ctrl #(.SAMPLE_GAP(GAP)) dut (.CLK_SYS(CLK_SYS), .RST(RST), .DEV_RESET_N(dev_reset_n),
		.RANGE_CODE_PINS(rpins), .CHANNEL_PICK_PINS(chpins), .REFERENCE_CHOICE_PIN(ref_pin),
		.AVG_RATIO_PINS(ospins), .CONVERSION_TRIGGER(trig), .SAMPLE_STROBE(strobe),
		.ADC_DATA_VALID(adc_valid), .ADC_A_DATA(adc_a), .ADC_B_DATA(adc_b), .CH_A_SEL(ch_a),
		.CH_B_SEL(ch_b), .RANGE_A_SEL(rng_a), .RANGE_B_SEL(rng_b), .LSB_UV_A(lsb_a),
		.LSB_UV_B(lsb_b), .RESULT(result), .RESULT_VALID(res_valid), .BUSY(busy),
		.HW_MODE(hw_mode), .REF_INT_EN(ref_int), .REF_BUF_EN(ref_buf), .SHUTDOWN(shutdown),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
		.HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp));
	daco_core_model u_core (.CLK_SYS(CLK_SYS), .RST(RST), .SLOW(slow), .SAMPLE_STROBE(strobe),
		.BUSY(busy), .RESULT_VALID(res_valid), .CH_A_SEL(ch_a), .CH_B_SEL(ch_b),
		.ADC_DATA_VALID(adc_valid), .ADC_A_DATA(adc_a), .ADC_B_DATA(adc_b));

	// ****************
	// tasks
	// ****************
	task automatic finish_test();
		$display("checked=%0d err_count=%0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// single word transfer
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK_SYS);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		@(posedge CLK_SYS);
		while (hreadyout !== 1'b1) @(posedge CLK_SYS);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge CLK_SYS);
		while (hreadyout !== 1'b1) @(posedge CLK_SYS);
		rd = hrdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// one trigger pulse; a second rising edge mid-run must be ignored
	task automatic conv(input logic retrig);
		@(posedge CLK_SYS);
		trig <= 1'b1;
		res_q.delete();
		n_strobe = 0;
		busy_len = 0;
		@(posedge CLK_SYS);
		trig <= 1'b0;
		repeat (4) @(posedge CLK_SYS);
		trig <= retrig;
		@(posedge CLK_SYS);
		trig <= 1'b0;
		while (busy === 1'b1) @(posedge CLK_SYS);
		@(posedge CLK_SYS);
	endtask

	// ****************
	// clock, observers and timeout
	// ****************
	initial begin
		CLK_SYS = 1'b0;
		forever #25 CLK_SYS = ~CLK_SYS;
	end
	// tallies and timeout
	always @(posedge CLK_SYS) begin
		cyc++;
		if (strobe === 1'b1) n_strobe++;
		if (busy === 1'b1) busy_len++;
		if (res_valid === 1'b1) res_q.push_back(result);
		if (cyc == LIMIT) begin
			err_count++;
			finish_test();
		end
	end

	// ****************
	// main sequence
	// ****************
	initial begin
		{dev_reset_n, ref_pin, trig, hsel, hwrite, slow} = 6'b110000;
		{rpins, htrans, chpins, ospins, haddr, hwdata} = '0;
		chpins = 3'h5; // pin channel must be ignored in software mode
		RST = 1'b1;
		repeat (8) @(posedge CLK_SYS);
		RST <= 1'b0;
		repeat (3) @(posedge CLK_SYS);
		chk(ref_buf, 1);
		rchk(daco_pkg::REG_STATUS, 32'h4);
		rchk(8'h20, 32'h0);
		for (int i = 0; i < 8; i++) begin
			r = rows[i];
			n = 1 << r.code;
			lat = r.slow ? 6 : 2;
			eca = (r.cha > 4'h8) ? 4'h8 : r.cha;
			ecb = (r.chb > 4'h8) ? 4'h8 : r.chb;
			er = (eca == 4'h8) ? 2'h3 : r.rng[2*eca +: 2];
			if (er == 2'h0) er = 2'h3;
			slow <= r.slow;
			bus(1'b1, daco_pkg::REG_CONFIG, {29'h0, r.code});
			bus(1'b1, daco_pkg::REG_CHANNEL, {24'h0, r.chb, r.cha});
			bus(1'b1, daco_pkg::REG_RANGE_A, {16'h0, r.rng});
			rchk(daco_pkg::REG_STATUS, {25'h0, r.code, 4'h4});
			chk(32'(ch_a), 32'(eca));
			chk(32'(ch_b), 32'(ecb));
			chk(32'(rng_a), 32'(er));
			chk(32'(rng_b), 32'h3);
			chk(32'(lsb_a), er == 2'h1 ? 32'h131 : er == 2'h2 ? 32'h262 : 32'h4C4);
			chk(32'(lsb_b), 32'h4C4);
			conv(1'b0);
			chk(n_strobe, n);
			chk(busy_len, (n - 1) * (lat + GAP + 1) + lat + 1);
			chk(res_q.size(), 1);
			chk(32'(res_q[0].a), 32'(14'(BA + 16 * eca + (n - 1) / 2)));
			chk(32'(res_q[0].b), 32'(14'(BB + 16 * ecb - n / 2)));
		end
		// short full reset: defaults back, no shutdown
		dev_reset_n <= 1'b0;
		repeat (10) @(posedge CLK_SYS);
		chk(shutdown, 0);
		dev_reset_n <= 1'b1;
		repeat (3) @(posedge CLK_SYS);
		chk(hw_mode, 0);
		rchk(daco_pkg::REG_CONFIG, 32'h0);
		rchk(daco_pkg::REG_CHANNEL, 32'h0);
		rchk(daco_pkg::REG_RANGE_A, 32'hFFFF);
		// sequencer over pairs 0..2 at ratio two, retriggered mid-run
		bus(1'b1, daco_pkg::REG_CONFIG, 32'h29);
		conv(1'b1);
		chk(n_strobe, 6);
		chk(res_q.size(), 3);
		for (int k = 0; k < 3; k++) begin
			chk(32'(res_q[k].a), 32'(14'(BA + 16 * k)));
			chk(32'(res_q[k].b), 32'(14'(BB + 16 * k - 1)));
		end
		// long low enters shutdown; release straps hardware mode, external reference
		{rpins, ospins, ref_pin, dev_reset_n} <= {2'h2, 3'h2, 1'b0, 1'b0};
		repeat (30) @(posedge CLK_SYS);
		chk(shutdown, 1);
		dev_reset_n <= 1'b1;
		repeat (3) @(posedge CLK_SYS);
		chk(shutdown, 0);
		chk(hw_mode, 1);
		chk(ref_int, 0);
		chk(32'(lsb_a), 32'h262);
		ospins <= 3'h7;
		chpins <= 3'h3;
		repeat (20) @(posedge CLK_SYS);
		rchk(daco_pkg::REG_STATUS, 32'h0);
		conv(1'b0);
		chk(n_strobe, 4);
		chk(32'(res_q[0].a), 32'(14'(BA + 48 + 1)));
		chk(32'(res_q[0].b), 32'(14'(BB + 48 - 2)));
		rpins <= 2'h1;
		repeat (2) @(posedge CLK_SYS);
		chk(32'(rng_b), 32'h1);
		chk(32'(lsb_a), 32'h131);
		rpins <= 2'h0;
		repeat (2) @(posedge CLK_SYS);
		chk(32'(rng_a), 32'h1);
		finish_test();
	end
endmodule
